/* mfg_command_unit.sv */
// manufacturer command interpreter and low-capacity threshold
`timescale 1ns/100ps
module mfg_command_unit #(
    parameter logic [39:0] IGNORE_CYCLES = 40'(mfg_cmd_pkg::IGNORE_CYC),
    parameter logic [39:0] STORAGE_CYCLES = 40'(mfg_cmd_pkg::STORAGE_DELAY_CYC),
    parameter logic [39:0] CLEAR_CYCLES = 40'(mfg_cmd_pkg::CLEAR_CYC),
    parameter logic [39:0] CAL_START_CYCLES = 40'(mfg_cmd_pkg::CAL_START_CYC),
    parameter logic [39:0] CAL_STOP_CYCLES = 40'(mfg_cmd_pkg::CAL_STOP_CYC),
    parameter logic [39:0] CAL_LIMIT_CYCLES = 40'(mfg_cmd_pkg::CAL_LIMIT_CYC),
    parameter logic [39:0] POST_CAL_CYCLES = 40'(mfg_cmd_pkg::POST_CAL_CYC)
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_ACK,
    input wire logic [15:0] EE_THRESHOLD,
    input wire logic EE_THRESHOLD_VALID,
    input wire logic CAPACITY_MODE,
    input wire logic [15:0] CHARGE_LEFT_VALUE,
    input wire logic [15:0] CHARGE_LEFT_MWH,
    input wire logic [15:0] FULL_CHARGE_CAPACITY_VALUE,
    input wire logic [7:0] FAST_CHARGE_TERM_PERCENT,
    input wire logic CAL_OFFSET_ZERO_DONE,
    input wire logic EE_SAVE_DONE,
    input wire logic BUS_ADDR_VALID,
    input wire logic [7:0] BUS_ADDR,
    input wire logic SERIAL_BUS_CLOCK_LINE,
    input wire logic SERIAL_BUS_DATA_LINE,
    input wire logic ONE_WIRE_LINE,
    output logic STORAGE_MODE,
    output logic SEALED,
    output logic REMAINING_CHARGE_LOAD,
    output logic [15:0] REMAINING_CHARGE_COUNT,
    output logic CAL_ACTIVE,
    output logic SENSE_DESELECT,
    output logic OFFSET_CORRECTION_EN,
    output logic EE_SAVE_REQ,
    output logic OFFSET_CALIBRATION_DONE,
    output logic LED_BLANK,
    output logic EEPROM_ROUTE,
    output logic EEPROM_POWER,
    output logic MONITOR_EN,
    output logic CAPACITY_ALARM
);
    import mfg_cmd_pkg::*;

    logic [15:0] manufacturer_command_word;
    logic [15:0] low_capacity_threshold;
    logic [39:0] since_reset;
    logic ignore_window;
    logic cmd_write;
    logic [15:0] cmd;
    logic storage_pending;
    logic storage_deferred;
    logic post_cal;
    cal_state_t cal_state;
    logic storage_done;
    logic clear_done;
    logic clear_busy;
    logic cal_tmr_done;
    logic cal_tmr_busy;
    logic [39:0] cal_tmr_count;
    logic cal_tmr_load;
    logic threshold_loaded;
    logic [2:0] wake_s1;
    logic [2:0] wake_s2;
    logic [2:0] wake_s3;
    logic wake;
    logic [23:0] charge_product;
    logic [15:0] compare_value;

    // two-flop synchronisers, reset to the idle pin levels so reset makes no false edge
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            wake_s1 <= 3'h6;
            wake_s2 <= 3'h6;
            wake_s3 <= 3'h6;
        end else begin
            wake_s1 <= {SERIAL_BUS_CLOCK_LINE, SERIAL_BUS_DATA_LINE, ONE_WIRE_LINE};
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
        end
    end
    assign wake = |(wake_s2 & ~wake_s3);

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            since_reset <= 40'h0;
            ignore_window <= 1'b1;
        end else if (ignore_window) begin
            since_reset <= since_reset + 40'h1;
            ignore_window <= (since_reset + 40'h1) < IGNORE_CYCLES;
        end
    end

    assign cmd_write = REG_WRITE && (REG_ADDR == REG_COMMAND) && !ignore_window;
    assign cmd = REG_WDATA;

    // only abort and seal while calibrating
    logic cal_busy;
    logic accept;
    assign cal_busy = (cal_state != CAL_IDLE);
    assign accept = cmd_write && (!cal_busy || cmd == CMD_CAL_STOP || cmd == CMD_SEAL)
        && !(SEALED && (cmd == CMD_CAL_CHIP || cmd == CMD_CAL_BOARD || cmd == CMD_EEPROM_ROUTE));
    logic start_cal;
    assign start_cal = accept && !SEALED && !cal_busy
        && (cmd == CMD_CAL_CHIP || cmd == CMD_CAL_BOARD);

    // write then clear after a fixed delay; clear chosen well inside 900 ms
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            manufacturer_command_word <= COMMAND_RESET;
        end else if (accept) begin
            manufacturer_command_word <= cmd;
        end else if (clear_done) begin
            manufacturer_command_word <= COMMAND_RESET;
        end
    end

    mfg_countdown clear_timer (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .load(accept),
        .cancel(1'b0),
        .count(CLEAR_CYCLES),
        .busy(clear_busy),
        .done(clear_done)
    );

    mfg_countdown storage_timer (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .load((accept && cmd == CMD_STORAGE) || (post_cal && cal_state == CAL_SAVE
            && EE_SAVE_DONE)),
        .cancel(wake && STORAGE_MODE),
        .count(post_cal && cal_state == CAL_SAVE ? POST_CAL_CYCLES : STORAGE_CYCLES),
        .busy(),
        .done(storage_done)
    );

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            storage_pending <= 1'b0;
            post_cal <= 1'b0;
        end else begin
            if (accept && cmd == CMD_STORAGE) begin
                storage_pending <= 1'b1;
            end else if (start_cal && storage_pending) begin
                post_cal <= 1'b1;
            end else if (storage_done && !cal_busy) begin
                storage_pending <= 1'b0;
                post_cal <= 1'b0;
            end
        end
    end
    assign storage_deferred = storage_pending && cal_busy;

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            STORAGE_MODE <= 1'b0;
        end else if (wake) begin
            STORAGE_MODE <= 1'b0;
        end else if (storage_done && storage_pending && !storage_deferred) begin
            STORAGE_MODE <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            SEALED <= 1'b0;
        end else if (accept && cmd == CMD_SEAL) begin
            SEALED <= 1'b1;
        end
    end

    assign charge_product = {8'h00, FULL_CHARGE_CAPACITY_VALUE} * {16'h0000, FAST_CHARGE_TERM_PERCENT};
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            REMAINING_CHARGE_LOAD <= 1'b0;
            REMAINING_CHARGE_COUNT <= 16'h0000;
        end else begin
            REMAINING_CHARGE_LOAD <= accept && cmd == CMD_CHARGE_SYNC;
            if (accept && cmd == CMD_CHARGE_SYNC) begin
                REMAINING_CHARGE_COUNT <= 16'(charge_product / 24'd100);
            end
        end
    end

    // calibration sequence
    always_comb begin
        cal_tmr_load = 1'b0;
        cal_tmr_count = CAL_START_CYCLES;
        if (start_cal) begin
            cal_tmr_load = 1'b1;
        end else if (accept && cmd == CMD_CAL_STOP && cal_busy) begin
            cal_tmr_load = 1'b1;
            cal_tmr_count = CAL_STOP_CYCLES;
        end else if (cal_state == CAL_WAIT && cal_tmr_done) begin
            cal_tmr_load = 1'b1;
            cal_tmr_count = CAL_LIMIT_CYCLES;
        end
    end

    mfg_countdown cal_timer (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .load(cal_tmr_load),
        .cancel(1'b0),
        .count(cal_tmr_count),
        .busy(cal_tmr_busy),
        .done(cal_tmr_done)
    );

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cal_state <= CAL_IDLE;
            SENSE_DESELECT <= 1'b0;
            OFFSET_CORRECTION_EN <= 1'b1;
            OFFSET_CALIBRATION_DONE <= 1'b0;
            EE_SAVE_REQ <= 1'b0;
        end else begin
            case (cal_state)
                CAL_IDLE: begin
                    if (start_cal) begin
                        SENSE_DESELECT <= (cmd == CMD_CAL_CHIP);
                        cal_state <= CAL_WAIT;
                    end
                end
                CAL_WAIT: begin
                    if (accept && cmd == CMD_CAL_STOP) begin
                        cal_state <= CAL_STOP;
                    end else if (cal_tmr_done) begin
                        OFFSET_CALIBRATION_DONE <= 1'b0;
                        cal_state <= CAL_RUN;
                    end
                end
                CAL_RUN: begin
                    if (accept && cmd == CMD_CAL_STOP) begin
                        cal_state <= CAL_STOP;
                    end else if (CAL_OFFSET_ZERO_DONE || cal_tmr_done) begin
                        EE_SAVE_REQ <= 1'b1;
                        cal_state <= CAL_SAVE;
                    end
                end
                CAL_SAVE: begin
                    if (EE_SAVE_DONE) begin
                        EE_SAVE_REQ <= 1'b0;
                        OFFSET_CALIBRATION_DONE <= 1'b1;
                        OFFSET_CORRECTION_EN <= 1'b1;
                        SENSE_DESELECT <= 1'b0;
                        cal_state <= CAL_IDLE;
                    end
                end
                CAL_STOP: begin
                    if (cal_tmr_done || !cal_tmr_busy) begin
                        OFFSET_CORRECTION_EN <= 1'b0;
                        SENSE_DESELECT <= 1'b0;
                        cal_state <= CAL_IDLE;
                    end
                end
                default: begin
                    cal_state <= CAL_IDLE;
                end
            endcase
        end
    end
    assign CAL_ACTIVE = (cal_state == CAL_RUN);
    assign LED_BLANK = cal_busy;

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            EEPROM_ROUTE <= 1'b0;
        end else if (EEPROM_ROUTE && BUS_ADDR_VALID && BUS_ADDR == BATTERY_ADDRESS) begin
            EEPROM_ROUTE <= 1'b0;
        end else if (accept && cmd == CMD_EEPROM_ROUTE && !SEALED) begin
            EEPROM_ROUTE <= 1'b1;
        end
    end
    assign EEPROM_POWER = EEPROM_ROUTE;
    assign MONITOR_EN = !EEPROM_ROUTE && !STORAGE_MODE;

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            low_capacity_threshold <= THRESHOLD_RESET;
            threshold_loaded <= 1'b0;
        end else if (REG_WRITE && REG_ADDR == REG_THRESHOLD) begin
            low_capacity_threshold <= REG_WDATA;
            threshold_loaded <= 1'b1;
        end else if (!threshold_loaded && EE_THRESHOLD_VALID) begin
            low_capacity_threshold <= EE_THRESHOLD;
            threshold_loaded <= 1'b1;
        end
    end

    assign compare_value = CAPACITY_MODE ? CHARGE_LEFT_MWH : CHARGE_LEFT_VALUE;
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            CAPACITY_ALARM <= 1'b0;
        end else begin
            CAPACITY_ALARM <= MONITOR_EN && (low_capacity_threshold != 16'h0000)
                && (compare_value < low_capacity_threshold);
        end
    end

    // register read port
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 16'h0000;
            REG_ACK <= 1'b0;
        end else begin
            REG_ACK <= REG_READ || REG_WRITE;
            if (REG_READ) begin
                case (REG_ADDR)
                    REG_COMMAND: REG_RDATA <= manufacturer_command_word;
                    REG_THRESHOLD: REG_RDATA <= low_capacity_threshold;
                    default: REG_RDATA <= 16'h0000;
                endcase
            end
        end
    end
endmodule

/* mfg_cmd_pkg.sv */
// constants and types shared by the manufacturer command unit
// Notes on behaviour
// - commands written within one second after reset may be ignored
// - code 0x0618 enters storage after 5 to 8 s; commands still accepted meanwhile
// - after storage code, command word clears to zero within 900 ms
// - calibration start during storage delay defers storage until offsets saved
// - code 0x062b seals the device and clears the command word within 900 ms
// - code 0x064d loads charge count with termination percent of full capacity
// - code 0x0653 unsealed starts calibration with sense inputs deselected
// - code 0x067e unsealed starts calibration with sense inputs connected
// - during calibration blank leds, accept only abort and seal codes
// - calibration finishes by itself and offsets are written to eeprom
// - calibration ends after at most one hour even at zero offset
// - after calibration code clear word within 900 ms, begin within 3.2 s
// - code 0x0660 aborts calibration within 20 ms, then disables offset correction
// - code 0x0606 unsealed routes bus to eeprom, powers it; monitoring suspended
// - battery address 0x16 seen on the bus disconnects the eeprom route
// - calibration-done flag clears at calibration start, sets on success only
// - deferred storage is entered about 20 s after calibration save
// - below nonzero threshold, alarm messages go out with capacity-alarm flag
// - threshold loads from eeprom bytes 0x04-0x05 at reset, kept until written
// - threshold in mAh when power-units bit is 0, 10 mWh when 1
// - in storage no gauging; rising edge on any bus line wakes the device
package mfg_cmd_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam logic [7:0] REG_COMMAND = 8'h00;
    localparam logic [7:0] REG_THRESHOLD = 8'h01;
    localparam logic [7:0] EE_THRESHOLD_LO = 8'h04;
    localparam logic [7:0] EE_THRESHOLD_HI = 8'h05;
    localparam logic [7:0] BATTERY_ADDRESS = 8'h16;
    localparam logic [15:0] CMD_STORAGE = 16'h0618;
    localparam logic [15:0] CMD_SEAL = 16'h062b;
    localparam logic [15:0] CMD_CHARGE_SYNC = 16'h064d;
    localparam logic [15:0] CMD_CAL_CHIP = 16'h0653;
    localparam logic [15:0] CMD_CAL_BOARD = 16'h067e;
    localparam logic [15:0] CMD_CAL_STOP = 16'h0660;
    localparam logic [15:0] CMD_EEPROM_ROUTE = 16'h0606;
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    // times in ms as printed, with counts derived from the clock
    localparam longint unsigned IGNORE_MS = 1000;
    localparam longint unsigned STORAGE_DELAY_MS = 6000;
    localparam longint unsigned CLEAR_MS = 500;
    localparam longint unsigned CAL_START_MS = 3000;
    localparam longint unsigned CAL_STOP_MS = 10;
    localparam longint unsigned CAL_LIMIT_MS = 3_600_000;
    localparam longint unsigned POST_CAL_MS = 20000;
    localparam longint unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam longint unsigned IGNORE_CYC = IGNORE_MS * CYC_PER_MS;
    localparam longint unsigned STORAGE_DELAY_CYC = STORAGE_DELAY_MS * CYC_PER_MS;
    localparam longint unsigned CLEAR_CYC = CLEAR_MS * CYC_PER_MS;
    localparam longint unsigned CAL_START_CYC = CAL_START_MS * CYC_PER_MS;
    localparam longint unsigned CAL_STOP_CYC = CAL_STOP_MS * CYC_PER_MS;
    localparam longint unsigned CAL_LIMIT_CYC = CAL_LIMIT_MS * CYC_PER_MS;
    localparam longint unsigned POST_CAL_CYC = POST_CAL_MS * CYC_PER_MS;
    typedef enum logic [2:0] {
        CAL_IDLE,
        CAL_WAIT,
        CAL_RUN,
        CAL_SAVE,
        CAL_STOP
    } cal_state_t;
endpackage

/* mfg_countdown.sv */
// loadable down counter that pulses when it reaches zero
`timescale 1ns/100ps
module mfg_countdown (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic cancel,
    input wire logic [39:0] count,
    output logic busy,
    output logic done
);
    logic [39:0] left;

    always_ff @(posedge clk) begin
        if (rst || cancel) begin
            left <= 40'h0;
            busy <= 1'b0;
        end else if (load) begin
            left <= count;
            busy <= 1'b1;
        end else if (busy) begin
            left <= left - 40'h1;
            if (left == 40'h1) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || cancel || load) begin
            done <= 1'b0;
        end else begin
            done <= busy && (left == 40'h1);
        end
    end
endmodule

/* mfg_command_unit_sva.sv */
// port assertions for the manufacturer command unit
`timescale 1ns/100ps
module mfg_command_unit_sva #(
    parameter logic [39:0] IGNORE_CYCLES = 40'h00_0000_0014
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic REG_WRITE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic STORAGE_MODE,
    input wire logic SEALED,
    input wire logic CAL_ACTIVE,
    input wire logic OFFSET_CORRECTION_EN,
    input wire logic OFFSET_CALIBRATION_DONE,
    input wire logic LED_BLANK,
    input wire logic EEPROM_ROUTE,
    input wire logic EEPROM_POWER,
    input wire logic MONITOR_EN,
    input wire logic BUS_ADDR_VALID,
    input wire logic [7:0] BUS_ADDR
);
    import mfg_cmd_pkg::*;
    // bounds fit the shortened counts used in the bench
    localparam int CAL_MAX = 12;
    localparam int STOP_MAX = 8;
    logic [39:0] up;
    logic armed, early, cmd_wr, cal_code;
    // cycles since reset; saturates once past the ignore window
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            up <= 40'h00_0000_0000;
        end else if (!armed) begin
            up <= up + 40'h00_0000_0001;
        end
    end
    // a margin on both sides keeps the window edge out of the checks
    assign armed = up > IGNORE_CYCLES + 40'h00_0000_0002;
    assign early = up + 40'h00_0000_0002 < IGNORE_CYCLES;
    assign cmd_wr = REG_WRITE && REG_ADDR == REG_COMMAND && !STORAGE_MODE;
    assign cal_code = REG_WDATA == CMD_CAL_CHIP || REG_WDATA == CMD_CAL_BOARD;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    sequence cal_begins;
        ##[1:CAL_MAX] CAL_ACTIVE;
    endsequence
    sequence cal_stops;
        ##[1:STOP_MAX] (!CAL_ACTIVE && !OFFSET_CORRECTION_EN);
    endsequence
    ignore_window_a: assert property (
        early && cmd_wr && REG_WDATA == CMD_SEAL |=> !SEALED)
        else $error("seal taken inside the ignore window");
    seal_taken_a: assert property (
        armed && cmd_wr && REG_WDATA == CMD_SEAL |=> SEALED)
        else $error("seal command not taken");
    cal_blanks_a: assert property (
        CAL_ACTIVE |-> LED_BLANK)
        else $error("display not blank during calibration");
    cal_start_a: assert property (
        armed && cmd_wr && cal_code && !SEALED && !LED_BLANK |-> cal_begins)
        else $error("calibration did not begin in time");
    cal_abort_a: assert property (
        CAL_ACTIVE && cmd_wr && REG_WDATA == CMD_CAL_STOP |-> cal_stops)
        else $error("abort did not stop calibration in time");
    route_effects_a: assert property (
        EEPROM_ROUTE |-> EEPROM_POWER && !MONITOR_EN)
        else $error("route up without power or with monitoring");
    route_drop_a: assert property (
        BUS_ADDR_VALID && BUS_ADDR == BATTERY_ADDRESS |-> ##[1:2] !EEPROM_ROUTE)
        else $error("battery address left the route connected");
    done_clear_a: assert property (
        $rose(CAL_ACTIVE) |-> ##1 !OFFSET_CALIBRATION_DONE)
        else $error("done flag not cleared at calibration start");
    sealed_ignore_a: assert property (
        armed && SEALED && cmd_wr && !LED_BLANK && !EEPROM_ROUTE
        && (cal_code || REG_WDATA == CMD_EEPROM_ROUTE)
        |=> (!CAL_ACTIVE && !EEPROM_ROUTE) [*8])
        else $error("sealed unit acted on a locked code");
endmodule

bind mfg_command_unit mfg_command_unit_sva #(.IGNORE_CYCLES(IGNORE_CYCLES)) chk (.*);

/* mfg_host_model.sv */
// host side model: word accesses, bus addresses and bus line wake
`timescale 1ns/100ps
module mfg_host_model #(
    parameter int GAP = 12
) (
    input wire logic REF_CLK,
    input wire logic REG_ACK,
    input wire logic [15:0] REG_RDATA,
    output logic REG_WRITE,
    output logic REG_READ,
    output logic [7:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    output logic BUS_ADDR_VALID,
    output logic [7:0] BUS_ADDR,
    output logic SERIAL_BUS_CLOCK_LINE,
    output logic SERIAL_BUS_DATA_LINE
);
    initial begin
        REG_WRITE = 1'b0;
        REG_READ = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 16'h0000;
        BUS_ADDR_VALID = 1'b0;
        BUS_ADDR = 8'h00;
        // lines sit at their pull-up level when idle
        SERIAL_BUS_CLOCK_LINE = 1'b1;
        SERIAL_BUS_DATA_LINE = 1'b1;
    end
    // one-cycle strobe; address and data are driven inverted once released
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        q = 16'hxxxx;
        @(negedge REF_CLK);
        REG_WRITE = wr;
        REG_READ = !wr;
        REG_ADDR = a;
        REG_WDATA = d;
        @(negedge REF_CLK);
        REG_WRITE = 1'b0;
        REG_READ = 1'b0;
        REG_ADDR = ~a;
        REG_WDATA = ~d;
        for (int i = 0; i < 4 && REG_ACK !== 1'b1; i++) @(negedge REF_CLK);
        if (REG_ACK === 1'b1) q = REG_RDATA;
    endtask
    // gap after the last eeprom write
    task automatic send_addr(input logic [7:0] a);
        repeat (GAP) @(negedge REF_CLK);
        BUS_ADDR = a;
        BUS_ADDR_VALID = 1'b1;
        @(negedge REF_CLK);
        BUS_ADDR_VALID = 1'b0;
        BUS_ADDR = ~a;
    endtask
    task automatic wake();
        @(negedge REF_CLK);
        SERIAL_BUS_CLOCK_LINE = 1'b0;
        repeat (2) @(negedge REF_CLK);
        SERIAL_BUS_CLOCK_LINE = 1'b1;
    endtask
endmodule

/* mfg_command_unit_tb.sv */
// self-checking bench for the manufacturer command unit
`timescale 1ns/100ps
module mfg_command_unit_tb;
    import mfg_cmd_pkg::*;
    // shortened counts so the whole run stays small
    localparam int IGN = 20, STO = 60, CLR = 10, CST = 8, CSP = 4, LIM = 100, PST = 30;
    logic REF_CLK = 1'b0, SYS_RST = 1'b1;
    logic REG_WRITE, REG_READ, REG_ACK, EE_THRESHOLD_VALID, CAPACITY_MODE, BUS_ADDR_VALID;
    logic [7:0] REG_ADDR, BUS_ADDR, FAST_CHARGE_TERM_PERCENT;
    logic [15:0] REG_WDATA, REG_RDATA, EE_THRESHOLD, CHARGE_LEFT_VALUE, CHARGE_LEFT_MWH, q;
    logic [15:0] FULL_CHARGE_CAPACITY_VALUE, REMAINING_CHARGE_COUNT;
    logic CAL_OFFSET_ZERO_DONE, EE_SAVE_DONE, SERIAL_BUS_CLOCK_LINE, SERIAL_BUS_DATA_LINE;
    logic ONE_WIRE_LINE, STORAGE_MODE, SEALED, REMAINING_CHARGE_LOAD, CAL_ACTIVE;
    logic SENSE_DESELECT, OFFSET_CORRECTION_EN, EE_SAVE_REQ, OFFSET_CALIBRATION_DONE;
    logic LED_BLANK, EEPROM_ROUTE, EEPROM_POWER, MONITOR_EN, CAPACITY_ALARM;
    int failures = 0, num_checks = 0;
    always #5 REF_CLK = ~REF_CLK;
    mfg_command_unit #(.IGNORE_CYCLES(40'(IGN)), .STORAGE_CYCLES(40'(STO)),
        .CLEAR_CYCLES(40'(CLR)), .CAL_START_CYCLES(40'(CST)), .CAL_STOP_CYCLES(40'(CSP)),
        .CAL_LIMIT_CYCLES(40'(LIM)), .POST_CAL_CYCLES(40'(PST))) DUT (.*);
    mfg_host_model host (.*);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        host.xfer(1'b0, a, 16'h0000, q);
        check(q, e);
    endtask
    task automatic cal_go(input logic [15:0] code);
        wr(REG_COMMAND, code);
        for (int i = 0; i < CST + 4 && !CAL_ACTIVE; i++) cyc(1);
        check(CAL_ACTIVE, 1'b1);
    endtask
    task automatic save_ack();
        EE_SAVE_DONE = 1'b1;
        cyc(1);
        EE_SAVE_DONE = 1'b0;
        cyc(3);
    endtask
    task automatic t_ignore();
        wr(REG_COMMAND, CMD_SEAL);
        check(SEALED, 1'b0);
        rd_chk(REG_COMMAND, COMMAND_RESET);
        cyc(IGN);
        $display("ignore window test done");
    endtask
    task automatic t_threshold();
        rd_chk(REG_THRESHOLD, 16'h0100);
        check(CAPACITY_ALARM, 1'b0);
        CHARGE_LEFT_VALUE = 16'h00ff;
        cyc(3);
        check(CAPACITY_ALARM, 1'b1);
        CAPACITY_MODE = 1'b1;
        cyc(3);
        check(CAPACITY_ALARM, 1'b0);
        CHARGE_LEFT_MWH = 16'h0050;
        cyc(3);
        check(CAPACITY_ALARM, 1'b1);
        wr(REG_THRESHOLD, 16'h0000);
        cyc(3);
        check(CAPACITY_ALARM, 1'b0);
        wr(REG_THRESHOLD, 16'h0300);
        EE_THRESHOLD_VALID = 1'b1;
        cyc(1);
        EE_THRESHOLD_VALID = 1'b0;
        rd_chk(REG_THRESHOLD, 16'h0300);
        CAPACITY_MODE = 1'b0;
        $display("threshold test done");
    endtask
    task automatic t_sync();
        FULL_CHARGE_CAPACITY_VALUE = 16'h03e8;
        FAST_CHARGE_TERM_PERCENT = 8'h5a;
        wr(REG_COMMAND, CMD_CHARGE_SYNC);
        for (int i = 0; i < CLR && !REMAINING_CHARGE_LOAD; i++) cyc(1);
        check(REMAINING_CHARGE_LOAD, 1'b1);
        check(REMAINING_CHARGE_COUNT, 16'h0384);
        cyc(CLR);
        rd_chk(REG_COMMAND, COMMAND_RESET);
        $display("charge sync test done");
    endtask
    task automatic t_storage();
        wr(REG_COMMAND, CMD_STORAGE);
        cyc(CLR + 2);
        rd_chk(REG_COMMAND, COMMAND_RESET);
        cyc(STO - CLR - 10);
        check(STORAGE_MODE, 1'b0);
        cyc(12);
        check(STORAGE_MODE, 1'b1);
        ONE_WIRE_LINE = 1'b1;
        cyc(6);
        check(STORAGE_MODE, 1'b0);
        ONE_WIRE_LINE = 1'b0;
        $display("storage test done");
    endtask
    task automatic t_cal_deferred();
        wr(REG_COMMAND, CMD_STORAGE);
        // start soon after the storage word clears
        cyc(CLR + 2);
        cal_go(CMD_CAL_CHIP);
        check(SENSE_DESELECT, 1'b1);
        check(LED_BLANK, 1'b1);
        check(OFFSET_CALIBRATION_DONE, 1'b0);
        cyc(CLR);
        wr(REG_COMMAND, CMD_CHARGE_SYNC);
        rd_chk(REG_COMMAND, COMMAND_RESET);
        cyc(STO);
        check(STORAGE_MODE, 1'b0);
        CAL_OFFSET_ZERO_DONE = 1'b1;
        cyc(1);
        CAL_OFFSET_ZERO_DONE = 1'b0;
        for (int i = 0; i < 8 && !EE_SAVE_REQ; i++) cyc(1);
        check(EE_SAVE_REQ, 1'b1);
        save_ack();
        check(OFFSET_CALIBRATION_DONE, 1'b1);
        check(CAL_ACTIVE, 1'b0);
        cyc(PST - 8);
        check(STORAGE_MODE, 1'b0);
        cyc(12);
        check(STORAGE_MODE, 1'b1);
        host.wake();
        cyc(6);
        check(STORAGE_MODE, 1'b0);
        $display("deferred calibration test done");
    endtask
    task automatic t_cal_stop();
        cal_go(CMD_CAL_BOARD);
        check(SENSE_DESELECT, 1'b0);
        wr(REG_COMMAND, CMD_CAL_STOP);
        cyc(CSP + 2);
        check(CAL_ACTIVE, 1'b0);
        check(OFFSET_CORRECTION_EN, 1'b0);
        check(OFFSET_CALIBRATION_DONE, 1'b0);
        // no convergence: only the time limit ends this run
        cal_go(CMD_CAL_CHIP);
        for (int i = 0; i < LIM + 4 && !EE_SAVE_REQ; i++) cyc(1);
        check(EE_SAVE_REQ, 1'b1);
        save_ack();
        check(CAL_ACTIVE, 1'b0);
        $display("calibration stop and limit test done");
    endtask
    task automatic t_route();
        wr(REG_COMMAND, CMD_EEPROM_ROUTE);
        cyc(CLR + 2);
        check(EEPROM_ROUTE, 1'b1);
        check(EEPROM_POWER, 1'b1);
        check(MONITOR_EN, 1'b0);
        host.send_addr(8'h17);
        cyc(2);
        check(EEPROM_ROUTE, 1'b1);
        host.send_addr(BATTERY_ADDRESS);
        cyc(2);
        check(EEPROM_ROUTE, 1'b0);
        check(MONITOR_EN, 1'b1);
        $display("eeprom route test done");
    endtask
    task automatic t_sealed();
        wr(REG_COMMAND, CMD_SEAL);
        check(SEALED, 1'b1);
        cyc(CLR + 2);
        rd_chk(REG_COMMAND, COMMAND_RESET);
        wr(REG_COMMAND, CMD_EEPROM_ROUTE);
        wr(REG_COMMAND, CMD_CAL_CHIP);
        rd_chk(REG_COMMAND, COMMAND_RESET);
        cyc(CST + 4);
        check(EEPROM_ROUTE, 1'b0);
        check(CAL_ACTIVE, 1'b0);
        $display("sealed test done");
    endtask
    initial begin
        EE_THRESHOLD = 16'h0100;
        EE_THRESHOLD_VALID = 1'b0;
        CAPACITY_MODE = 1'b0;
        CHARGE_LEFT_VALUE = 16'h0400;
        CHARGE_LEFT_MWH = 16'h0200;
        FULL_CHARGE_CAPACITY_VALUE = 16'h0000;
        FAST_CHARGE_TERM_PERCENT = 8'h00;
        CAL_OFFSET_ZERO_DONE = 1'b0;
        EE_SAVE_DONE = 1'b0;
        // the one-wire line idles at its pull-down level
        ONE_WIRE_LINE = 1'b0;
        cyc(4);
        SYS_RST = 1'b0;
        EE_THRESHOLD_VALID = 1'b1;
        cyc(1);
        EE_THRESHOLD_VALID = 1'b0;
        t_ignore();
        t_threshold();
        t_sync();
        t_storage();
        t_cal_deferred();
        t_cal_stop();
        t_route();
        t_sealed();
        stop_test();
    end
    initial begin
        cyc(5000);
        failures++;
        stop_test();
    end
endmodule
